// ### hw/fifo_read_pkg.sv
// constants shared by the read-port control block and its store
package fifo_read_pkg;
  localparam int          DATA_W         = 20;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          PTR_W          = 4;
  localparam int          OFF_W          = 4;
  localparam logic [3:0]  EMPTY_OFF_INIT = 4'h2;
  localparam logic [3:0]  FULL_OFF_INIT  = 4'h2;
  localparam logic [1:0]  POP_NONE       = 2'h0;
  localparam logic [1:0]  POP_ONE        = 2'h1;
  localparam logic [1:0]  POP_TWO        = 2'h2;
  // clk_i side pin synchroniser bit positions
  localparam int          CS_MRS         = 0;
  localparam int          CS_PRS         = 1;
  localparam int          CS_SCLK        = 2;
  localparam int          CS_SIN         = 3;
  localparam int          CS_SLOAD       = 4;
  localparam int          CS_SREAD       = 5;
  localparam int          CS_W           = 6;
  // read clock side pin synchroniser bit positions
  localparam int          RS_MRS         = 0;
  localparam int          RS_PRS         = 1;
  localparam int          RS_OE          = 2;
  localparam int          RS_RATE        = 3;
  localparam int          RS_FALL_THROUGH_MODE        = 4;
  localparam int          RS_W           = 5;
endpackage

// ### hw/fifo_read_port.sv
// read-port control: chip select, rate, retransmit, serial offsets, flags
`timescale 1ns/1ps
`default_nettype none
module fifo_read_port
  import fifo_read_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              wr_valid_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  output logic                   wr_ready_o,
  input  wire logic              master_reset_n_i,
  input  wire logic              partial_reset_n_i,
  input  wire logic              fall_through_mode_i,
  input  wire logic              sclk_i,
  input  wire logic              serial_in_i,
  input  wire logic              serial_load_enable_n_i,
  input  wire logic              serial_readback_enable_n_i,
  output logic                   serial_out_o,
  output logic                   almost_empty_flag_n_o,
  output logic                   almost_full_flag_n_o,
  input  wire logic              rclk_i,
  input  wire logic              read_chip_select_n_i,
  input  wire logic              read_enable_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              read_rate_select_i,
  input  wire logic              retransmit_n_i,
  input  wire logic              mark_i,
  output logic [DATA_W-1:0]      q_rise_o,
  output logic [DATA_W-1:0]      q_fall_o,
  output logic                   q_oe_o,
  output logic                   empty_flag_n_o
);
  logic [CS_W-1:0]      cs1_r, cs2_r;
  logic                 sclk_d_r;
  logic [RS_W-1:0]      rs1_r, rs2_r;
  logic                 clr_c, clr_r, sclk_rise;
  logic [2*OFF_W-1:0]   off_r;
  logic [OFF_W-1:0]     empty_off, full_off;
  logic [PTR_W-1:0]     wr_count, rd_count;
  logic                 rd_valid;
  logic [DATA_W-1:0]    data1;
  logic                 in_reset, ddr, read_go, rt_go;
  logic                 fall_through_mode_r, out_valid_r, out_valid_nxt, flag_nxt;
  logic [1:0]           pop;

  // pins from outside both clocks pass two flops first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs1_r    <= '0;
      cs2_r    <= '0;
      sclk_d_r <= 1'b0;
    end else begin
      cs1_r    <= {serial_readback_enable_n_i, serial_load_enable_n_i, serial_in_i,
                   sclk_i, partial_reset_n_i, master_reset_n_i};
      cs2_r    <= cs1_r;
      sclk_d_r <= cs2_r[CS_SCLK];
    end
  end

  always_ff @(posedge rclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rs1_r <= '0;
      rs2_r <= '0;
    end else begin
      rs1_r <= {fall_through_mode_i, read_rate_select_i, output_enable_n_i,
                partial_reset_n_i, master_reset_n_i};
      rs2_r <= rs1_r;
    end
  end

  assign clr_c     = !cs2_r[CS_MRS] || !cs2_r[CS_PRS];
  assign clr_r     = !rs2_r[RS_MRS] || !rs2_r[RS_PRS];
  assign sclk_rise = cs2_r[CS_SCLK] && !sclk_d_r;
  assign empty_off = off_r[2*OFF_W-1:OFF_W];
  assign full_off  = off_r[OFF_W-1:0];

  fifo_store #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_store (
    .wclk_i      (clk_i),
    .wrstn_i     (rstn_i),
    .wclr_i      (clr_c),
    .wr_valid_i  (wr_valid_i),
    .wr_ready_o  (wr_ready_o),
    .wr_data_i   (wr_data_i),
    .wr_count_o  (wr_count),
    .rclk_i      (rclk_i),
    .rrstn_i     (rstn_i),
    .rclr_i      (clr_r),
    .rd_pop_i    (pop),
    .rd_rewind_i (rt_go),
    .rd_mark_i   (mark_i && !clr_r),
    .rd_valid_o  (rd_valid),
    .rd_count_o  (rd_count),
    .rd_data0_o  (q_rise_o),
    .rd_data1_o  (data1)
  );

  // offsets: empty in upper half, full in lower; only master reset restores them
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      off_r        <= {EMPTY_OFF_INIT, FULL_OFF_INIT};
      serial_out_o <= 1'b0;
    end else if (!cs2_r[CS_MRS]) begin
      off_r        <= {EMPTY_OFF_INIT, FULL_OFF_INIT};
      serial_out_o <= 1'b0;
    end else if (sclk_rise && !cs2_r[CS_SLOAD]) begin
      off_r        <= {off_r[2*OFF_W-2:0], cs2_r[CS_SIN]};
    end else if (sclk_rise && !cs2_r[CS_SREAD]) begin
      serial_out_o <= off_r[2*OFF_W-1];
      off_r        <= {off_r[2*OFF_W-2:0], off_r[2*OFF_W-1]};
    end
  end

  // flags from write-side count; lag of the far pointer keeps almost-full cautious but delays almost-empty
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      almost_empty_flag_n_o <= 1'b0;
      almost_full_flag_n_o  <= 1'b1;
    end else begin
      almost_empty_flag_n_o <= wr_count >= PTR_W'(empty_off);
      almost_full_flag_n_o  <= (PTR_W'(FIFO_DEPTH) - wr_count) > PTR_W'(full_off);
    end
  end

  assign in_reset = clr_r;
  assign ddr      = rs2_r[RS_RATE];
  assign read_go  = !read_enable_n_i && !read_chip_select_n_i && !in_reset;
  assign rt_go    = !retransmit_n_i && !in_reset;

  // fall-through strap is caught while master reset is held; not offered in ddr
  always_ff @(posedge rclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fall_through_mode_r <= 1'b0;
    end else if (!rs2_r[RS_MRS]) begin
      fall_through_mode_r <= rs2_r[RS_FALL_THROUGH_MODE] && !rs2_r[RS_RATE];
    end
  end

  always_comb begin
    pop = POP_NONE;
    if (in_reset || rt_go) begin
      pop = POP_NONE;
    end else if (fall_through_mode_r) begin
      if (rd_valid && (!out_valid_r || read_go)) begin
        pop = POP_ONE;
      end
    end else if (read_go && rd_valid) begin
      pop = (ddr && rd_count >= PTR_W'(2)) ? POP_TWO : POP_ONE;
    end
  end

  always_comb begin
    out_valid_nxt = out_valid_r;
    if (in_reset || rt_go) begin
      out_valid_nxt = 1'b0;
    end else if (pop != POP_NONE) begin
      out_valid_nxt = 1'b1;
    end else if (read_go) begin
      out_valid_nxt = 1'b0;
    end
    if (rt_go) begin
      flag_nxt = fall_through_mode_r;
    end else if (fall_through_mode_r) begin
      flag_nxt = !out_valid_nxt;
    end else begin
      flag_nxt = rd_count != '0;
    end
  end

  always_ff @(posedge rclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_valid_r    <= 1'b0;
      empty_flag_n_o <= 1'b0;
    end else begin
      out_valid_r    <= out_valid_nxt;
      empty_flag_n_o <= in_reset ? fall_through_mode_r : flag_nxt;
    end
  end

  // chip select ignored in reset; output enable pin must also be low in both cases
  always_ff @(posedge rclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_oe_o <= 1'b0;
    end else begin
      q_oe_o <= !rs2_r[RS_OE] && (in_reset || !read_chip_select_n_i);
    end
  end

  // second word of a double-rate read goes out on the falling edge
  always_ff @(negedge rclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_fall_o <= '0;
    end else begin
      q_fall_o <= data1;
    end
  end

  sequence s_cs_off;
    read_chip_select_n_i && !in_reset;
  endsequence

  sequence s_rt_req;
    rt_go ##0 !in_reset;
  endsequence

  a_cs_blocks_read : assert property (@(posedge rclk_i) disable iff (!rstn_i)
    s_cs_off |-> (pop == POP_NONE || fall_through_mode_r))
    else $error("read taken while chip select high");

  a_cs_drives_oe : assert property (@(posedge rclk_i) disable iff (!rstn_i)
    (s_cs_off ##0 !rs2_r[RS_OE]) |=> !q_oe_o)
    else $error("outputs driven while deselected");

  a_reset_drives : assert property (@(posedge rclk_i) disable iff (!rstn_i)
    (in_reset && !rs2_r[RS_OE]) |=> q_oe_o)
    else $error("outputs not driven during reset with output enable low");

  a_ddr_two_words : assert property (@(posedge rclk_i) disable iff (!rstn_i)
    (ddr && read_go && !rt_go && !fall_through_mode_r && rd_count >= PTR_W'(2)) |-> pop == POP_TWO)
    else $error("double rate read moved fewer than two words");

  a_sdr_one_word : assert property (@(posedge rclk_i) disable iff (!rstn_i)
    !ddr |-> pop != POP_TWO)
    else $error("single rate read moved two words");

  a_rt_flag : assert property (@(posedge rclk_i) disable iff (!rstn_i)
    s_rt_req |=> (empty_flag_n_o == $past(fall_through_mode_r)) && !out_valid_r)
    else $error("retransmit did not show no-data on flag");

  a_offset_shift : assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sclk_rise && !cs2_r[CS_SLOAD] && cs2_r[CS_MRS])
      |=> off_r == {$past(off_r[2*OFF_W-2:0]), $past(cs2_r[CS_SIN])})
    else $error("serial load did not shift offsets");

  a_offset_read : assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sclk_rise && cs2_r[CS_SLOAD] && !cs2_r[CS_SREAD] && cs2_r[CS_MRS])
      |=> serial_out_o == $past(off_r[2*OFF_W-1]))
    else $error("serial readback bit wrong");

  a_offsets_hold : assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!sclk_rise && cs2_r[CS_MRS]) |=> $stable(off_r))
    else $error("offsets changed without serial access");

  a_almost_full : assert property (@(posedge clk_i) disable iff (!rstn_i)
    1'b1 |=> almost_full_flag_n_o
      == ((PTR_W'(FIFO_DEPTH) - $past(wr_count)) > PTR_W'($past(full_off))))
    else $error("almost full flag wrong");
endmodule
`default_nettype wire

// ### hw/fifo_store.sv
// dual-clock word store with gray pointers, mark/rewind and registered read data
`timescale 1ns/1ps
`default_nettype none
module fifo_store
  import fifo_read_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             wclk_i,
  input  wire logic             wrstn_i,
  input  wire logic             wclr_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic [PTR_W-1:0]      wr_count_o,
  input  wire logic             rclk_i,
  input  wire logic             rrstn_i,
  input  wire logic             rclr_i,
  input  wire logic [1:0]       rd_pop_i,
  input  wire logic             rd_rewind_i,
  input  wire logic             rd_mark_i,
  output logic                  rd_valid_o,
  output logic [PTR_W-1:0]      rd_count_o,
  output logic [WIDTH-1:0]      rd_data0_o,
  output logic [WIDTH-1:0]      rd_data1_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr_r, wptr_nxt, wgray_r, rgs1_r, rgs2_r, rbin_w;
  logic [PTR_W-1:0] rptr_r, rptr_nxt, rgray_r, wgs1_r, wgs2_r, wbin_r, mark_r;
  logic             push;

  function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    from_gray = b;
  endfunction

  assign push     = wr_valid_i && wr_ready_o;
  assign wptr_nxt = wptr_r + PTR_W'(push);
  assign rbin_w   = from_gray(rgs2_r);
  assign wbin_r   = from_gray(wgs2_r);

  always_ff @(posedge wclk_i or negedge wrstn_i) begin
    if (!wrstn_i) begin
      wptr_r     <= '0;
      wgray_r    <= '0;
      wr_count_o <= '0;
      wr_ready_o <= 1'b0;
    end else if (wclr_i) begin
      wptr_r     <= '0;
      wgray_r    <= '0;
      wr_count_o <= '0;
      wr_ready_o <= 1'b0;
    end else begin
      wptr_r     <= wptr_nxt;
      wgray_r    <= to_gray(wptr_nxt);
      wr_count_o <= wptr_nxt - rbin_w;
      // ready lags the far pointer, so it only errs toward full
      wr_ready_o <= (wptr_nxt - rbin_w) != PTR_W'(DEPTH);
    end
  end

  always_ff @(posedge wclk_i) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge wclk_i or negedge wrstn_i) begin
    if (!wrstn_i) begin
      rgs1_r <= '0;
      rgs2_r <= '0;
    end else begin
      rgs1_r <= rgray_r;
      rgs2_r <= rgs1_r;
    end
  end

  always_ff @(posedge rclk_i or negedge rrstn_i) begin
    if (!rrstn_i) begin
      wgs1_r <= '0;
      wgs2_r <= '0;
    end else begin
      wgs1_r <= wgray_r;
      wgs2_r <= wgs1_r;
    end
  end

  // rewind only moves the read pointer; write side is untouched
  assign rptr_nxt = rd_rewind_i ? mark_r : rptr_r + PTR_W'(rd_pop_i);

  always_ff @(posedge rclk_i or negedge rrstn_i) begin
    if (!rrstn_i) begin
      mark_r <= '0;
    end else if (rclr_i) begin
      mark_r <= '0;
    end else if (rd_mark_i) begin
      mark_r <= rptr_r;
    end
  end

  always_ff @(posedge rclk_i or negedge rrstn_i) begin
    if (!rrstn_i) begin
      rptr_r     <= '0;
      rgray_r    <= '0;
      rd_count_o <= '0;
      rd_valid_o <= 1'b0;
    end else if (rclr_i) begin
      rptr_r     <= '0;
      rgray_r    <= '0;
      rd_count_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rptr_r     <= rptr_nxt;
      rgray_r    <= to_gray(rptr_nxt);
      rd_count_o <= wbin_r - rptr_nxt;
      rd_valid_o <= wbin_r != rptr_nxt;
    end
  end

  always_ff @(posedge rclk_i or negedge rrstn_i) begin
    if (!rrstn_i) begin
      rd_data0_o <= '0;
      rd_data1_o <= '0;
    end else if (rclr_i) begin
      rd_data0_o <= '0;
      rd_data1_o <= '0;
    end else begin
      if (rd_pop_i != POP_NONE) begin
        rd_data0_o <= mem[rptr_r[AW-1:0]];
      end
      if (rd_pop_i == POP_TWO) begin
        rd_data1_o <= mem[AW'(rptr_r + PTR_W'(1))];
      end
    end
  end

  a_rewind_target : assert property (@(posedge rclk_i) disable iff (!rrstn_i)
    (rd_rewind_i && !rclr_i) |=> (rptr_r == $past(mark_r)))
    else $error("read pointer did not land on mark after rewind");

  a_mark_latest : assert property (@(posedge rclk_i) disable iff (!rrstn_i)
    (rd_mark_i && !rclr_i) |=> (mark_r == $past(rptr_r)))
    else $error("mark did not capture read pointer");
endmodule
`default_nettype wire

// ### testbench/fifo_read_port_bench.sv
// self-checking bench for the fifo read-port control block
`timescale 1ns/1ps
`default_nettype none
module fifo_read_port_bench;
  import fifo_read_pkg::*;
  logic              clk_i, rstn_i, rclk_i, wr_valid, wr_ready, master_reset_n, partial_reset_n;
  logic              sclk, serial_in, load_n, rdbk_n, serial_out, ae_n, af_n, q_oe, empty_n;
  logic              cs_n, ren_n, oe_n, rate, retx_n, mk, fall_through_mode;
  logic [DATA_W-1:0] wr_data, q_rise, q_fall;
  int                mismatches, total_checks, cycles;

  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  // read clock offset so its edges never line up with clk_i
  initial begin
    rclk_i = 1'h0;
    #1.3;
    forever #3 rclk_i = ~rclk_i;
  end

  read_side_model model (.rclk_i(rclk_i), .read_chip_select_n_o(cs_n), .read_enable_n_o(ren_n),
    .retransmit_n_o(retx_n), .mark_o(mk), .output_enable_n_o(oe_n), .read_rate_select_o(rate));

  fifo_read_port uut (.clk_i(clk_i), .rstn_i(rstn_i), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
    .wr_ready_o(wr_ready), .master_reset_n_i(master_reset_n), .partial_reset_n_i(partial_reset_n),
    .fall_through_mode_i(fall_through_mode), .sclk_i(sclk), .serial_in_i(serial_in),
    .serial_load_enable_n_i(load_n), .serial_readback_enable_n_i(rdbk_n),
    .serial_out_o(serial_out), .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n),
    .rclk_i(rclk_i), .read_chip_select_n_i(cs_n), .read_enable_n_i(ren_n),
    .output_enable_n_i(oe_n), .read_rate_select_i(rate), .retransmit_n_i(retx_n),
    .mark_i(mk), .q_rise_o(q_rise), .q_fall_o(q_fall), .q_oe_o(q_oe), .empty_flag_n_o(empty_n));

  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [DATA_W-1:0] w(input int i);
    return 20'h1_0000 + DATA_W'(i);
  endfunction

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // request held until ready is seen high at a sampling edge
  task automatic wr(input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    wr_valid = 1'h1;
    wr_data  = d;
    @(negedge clk_i);
    while (wr_ready !== 1'h1 && n < 50) begin
      n++;
      @(negedge clk_i);
    end
    chk_bit(wr_ready, 1'h1);
    @(posedge clk_i);
    #1;
    wr_valid = 1'h0;
  endtask

  task automatic pop(input logic cs, input logic [DATA_W-1:0] exp);
    model.op(cs, 1'h0, 1'h1, 1'h0);
    @(posedge rclk_i);
    #1;
    chk_word(q_rise, exp);
  endtask

  // the no-data flag stands one read clock only, so look right after the taking edge
  task automatic retx(input logic exp_flag);
    model.op(1'h0, 1'h1, 1'h0, 1'h0);
    chk_bit(empty_n, exp_flag);
    @(posedge rclk_i);
    #1;
  endtask

  // slow serial clock: the pins pass a two-flop synchroniser first
  task automatic sbit(input logic ld, input logic rd, input logic b, output logic so);
    load_n    = ld;
    rdbk_n    = rd;
    serial_in = b;
    wait_clk(8);
    sclk = 1'h1;
    wait_clk(8);
    so   = serial_out;
    sclk = 1'h0;
    wait_clk(8);
    load_n = 1'h1;
    rdbk_n = 1'h1;
  endtask

  task automatic sload(input logic [7:0] v);
    logic so;
    for (int i = 7; i >= 0; i--) sbit(1'h0, 1'h1, v[i], so);
  endtask

  task automatic sread(input logic [7:0] exp);
    logic [7:0] got;
    for (int i = 7; i >= 0; i--) sbit(1'h1, 1'h0, 1'h0, got[i]);
    chk_word({12'h000, got}, {12'h000, exp});
  endtask

  initial begin
    mismatches = 0; total_checks = 0; cycles = 0;
    rstn_i = 1'h0; wr_valid = 1'h0; wr_data = '0; master_reset_n = 1'h1;
    partial_reset_n = 1'h1; sclk = 1'h0; serial_in = 1'h0; load_n = 1'h1; rdbk_n = 1'h1;
    fall_through_mode = 1'h0;
    repeat (6) @(posedge clk_i);
    #1;
    rstn_i = 1'h1;
    wait_clk(8);
    chk_bit(ae_n, 1'h0);
    chk_bit(af_n, 1'h1);
    for (int i = 0; i < 8; i++) begin
      wr(w(i));
      wait_clk(24);
      chk_bit(ae_n, i + 1 >= 2);
      chk_bit(af_n, 7 - i > 2);
    end
    chk_bit(wr_ready, 1'h0);
    model.op(1'h1, 1'h1, 1'h1, 1'h0);
    repeat (2) @(posedge rclk_i);
    #1;
    chk_bit(q_oe, 1'h0);
    pop(1'h1, 20'h0_0000);
    pop(1'h0, w(0));
    chk_bit(q_oe, 1'h1);
    model.op(1'h0, 1'h1, 1'h1, 1'h1);
    pop(1'h0, w(1));
    model.op(1'h0, 1'h1, 1'h1, 1'h1);
    pop(1'h0, w(2));
    retx(1'h0);
    pop(1'h0, w(2));
    sread(8'h22);
    sload(8'h51);
    sread(8'h51);
    // outputs must stay driven in reset even with the port deselected
    model.op(1'h1, 1'h1, 1'h1, 1'h0);
    partial_reset_n = 1'h0;
    wait_clk(12);
    chk_bit(q_oe, 1'h1);
    partial_reset_n = 1'h1;
    wait_clk(12);
    for (int i = 16; i < 20; i++) wr(w(i));
    wait_clk(24);
    chk_bit(ae_n, 1'h0);
    wr(w(20));
    wait_clk(24);
    chk_bit(ae_n, 1'h1);
    pop(1'h0, w(16));
    pop(1'h0, w(17));
    retx(1'h0);
    pop(1'h0, w(16));
    master_reset_n = 1'h0;
    model.set_rate(1'h1);
    wait_clk(12);
    master_reset_n = 1'h1;
    wait_clk(12);
    for (int i = 32; i < 36; i++) wr(w(i));
    wait_clk(24);
    for (int i = 32; i < 36; i += 2) begin
      model.op(1'h0, 1'h0, 1'h1, 1'h0);
      @(posedge rclk_i);
      @(negedge rclk_i);
      #1;
      chk_word(q_rise, w(i));
      chk_word(q_fall, w(i + 1));
    end
    // fall-through strap caught in master reset; single rate so it is honoured
    master_reset_n = 1'h0;
    fall_through_mode = 1'h1;
    model.set_rate(1'h0);
    wait_clk(12);
    master_reset_n = 1'h1;
    wait_clk(12);
    wr(w(40));
    wr(w(41));
    wait_clk(24);
    chk_word(q_rise, w(40));
    chk_bit(empty_n, 1'h0);
    pop(1'h0, w(41));
    retx(1'h1);
    chk_word(q_rise, w(40));
    conclude();
  end
endmodule
`default_nettype wire

// ### testbench/read_side_model.sv
// read-side controller model driving the read port of the fifo
`timescale 1ns/1ps
`default_nettype none
module read_side_model (
  input  wire logic rclk_i,
  output logic      read_chip_select_n_o,
  output logic      read_enable_n_o,
  output logic      retransmit_n_o,
  output logic      mark_o,
  output logic      output_enable_n_o,
  output logic      read_rate_select_o
);
  initial begin
    read_chip_select_n_o = 1'h1;
    read_enable_n_o      = 1'h1;
    retransmit_n_o       = 1'h1;
    mark_o               = 1'h0;
    output_enable_n_o    = 1'h0;
    read_rate_select_o   = 1'h0;
  end
  // only called while master reset is held, never in operation
  task automatic set_rate(input logic r);
    read_rate_select_o = r;
  endtask
  // one request cycle; chip select is left where it was put
  task automatic op(input logic cs_n, input logic ren_n, input logic retx_n, input logic mk);
    @(posedge rclk_i);
    #1;
    read_chip_select_n_o = cs_n;
    read_enable_n_o      = ren_n;
    retransmit_n_o       = retx_n;
    mark_o               = mk;
    @(posedge rclk_i);
    #1;
    read_enable_n_o = 1'h1;
    retransmit_n_o  = 1'h1;
    mark_o          = 1'h0;
  endtask
endmodule
`default_nettype wire
